// File: rtl/bus_sync.sv
`timescale 1ns/100ps
module bus_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule

// File: rtl/eeprom_bus_master.sv
`timescale 1ns/100ps
module eeprom_bus_master
  import eeprom_cache_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Two-wire link
  eeprom_link_if.host link,
  // Request
  input wire logic req_valid,
  input wire req_kind_t req_kind,
  input wire logic [2:0] req_cs,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [6:0] req_len,
  input wire logic [7:0] wr_data,
  // Answer
  output logic busy,
  output logic data_take,
  output logic done,
  output logic nack,
  output logic [7:0] rd_byte
);
  logic sda_s;
  host_state_t st_ff;
  req_kind_t kind_ff;
  logic [2:0] cs_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] last_ff;
  logic [QCNT_W-1:0] qcnt_ff;
  logic [1:0] q_ff;
  logic [3:0] b_ff;
  logic [7:0] k_ff;
  logic [7:0] sh_ff;
  logic scl_ff;
  logic oe_ff;
  logic busy_ff;
  logic take_ff;
  logic done_ff;
  logic nack_ff;
  logic [7:0] rd_ff;
  logic tick;
  logic rx_mode;
  logic [7:0] next_tx;
  logic [7:0] nxt_k;

  bus_sync #(.W(1)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(link.sda),
    .q(sda_s)
  );

  assign tick = qcnt_ff == '0;
  assign rx_mode = kind_ff == K_READ && k_ff == 8'h01;
  assign nxt_k = k_ff + 8'h01;
  always_comb begin
    unique case (nxt_k)
      8'h01: next_tx = {3'h0, addr_ff[ADDR_W-1:ADDR_HI_LSB]};
      8'h02: next_tx = addr_ff[ADDR_HI_LSB-1:0];
      default: next_tx = wr_data;
    endcase
  end

  // Quarter-bit timebase; the link clock is divided from clk_sys
  always_ff @(posedge clk_sys) begin
    if (rst || st_ff == H_IDLE)
      qcnt_ff <= QCNT_W'(QTR - 1);
    else if (tick)
      qcnt_ff <= QCNT_W'(QTR - 1);
    else
      qcnt_ff <= qcnt_ff - QCNT_W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= H_IDLE;
      kind_ff <= K_WRITE;
      cs_ff <= 3'h0;
      addr_ff <= '0;
      last_ff <= 8'h00;
      q_ff <= 2'h0;
      b_ff <= 4'h0;
      k_ff <= 8'h00;
      sh_ff <= 8'h00;
      scl_ff <= SCL_IDLE;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      take_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      rd_ff <= 8'h00;
    end else begin
      take_ff <= 1'b0;
      done_ff <= 1'b0;
      unique case (st_ff)
        H_IDLE: begin
          if (req_valid) begin
            kind_ff <= req_kind;
            cs_ff <= req_cs;
            addr_ff <= req_addr;
            last_ff <= 8'(req_len) + 8'h02;
            nack_ff <= 1'b0;
            busy_ff <= 1'b1;
            q_ff <= 2'h0;
            st_ff <= H_START;
          end
        end
        H_START: if (tick) begin
          q_ff <= q_ff + 2'h1;
          if (q_ff == 2'h1)
            oe_ff <= 1'b1;
          if (q_ff == 2'h3) begin
            scl_ff <= 1'b0;
            st_ff <= H_BIT;
            b_ff <= 4'h0;
            k_ff <= 8'h00;
            nack_ff <= 1'b0;
            sh_ff <= {DEV_TYPE, cs_ff, kind_ff == K_READ};
          end
        end
        H_BIT: if (tick) begin
          q_ff <= q_ff + 2'h1;
          unique case (q_ff)
            // Drive data a quarter after the falling clock edge
            2'h0: oe_ff <= b_ff < 4'(ACK_BIT) && !rx_mode && !sh_ff[7];
            2'h1: scl_ff <= 1'b1;
            2'h2: begin
            end
            2'h3: begin
              scl_ff <= 1'b0;
              if (b_ff < 4'(ACK_BIT)) begin
                sh_ff <= {sh_ff[6:0], sda_s};
                b_ff <= b_ff + 4'h1;
                // Let go with the clock fall so the ack never overlaps
                if (b_ff == 4'h7)
                  oe_ff <= 1'b0;
              end else if (rx_mode) begin
                rd_ff <= sh_ff;
                st_ff <= H_STOP;
              end else if (sda_s) begin
                nack_ff <= 1'b1;
                st_ff <= H_STOP;
              end else if (kind_ff == K_POLL ||
                  (kind_ff == K_WRITE && k_ff == last_ff)) begin
                st_ff <= H_STOP;
              end else begin
                k_ff <= nxt_k;
                b_ff <= 4'h0;
                sh_ff <= next_tx;
                take_ff <= kind_ff == K_WRITE && nxt_k >= 8'(FIRST_DATA_IDX);
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          q_ff <= q_ff + 2'h1;
          unique case (q_ff)
            2'h0: oe_ff <= 1'b1;
            2'h1: scl_ff <= 1'b1;
            2'h2: oe_ff <= 1'b0;
            2'h3: begin
              // Polling repeats until the device answers
              if (kind_ff == K_POLL && nack_ff) begin
                st_ff <= H_START;
              end else begin
                st_ff <= H_IDLE;
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
              end
            end
          endcase
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign link.scl = scl_ff;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_ff;
  assign busy = busy_ff;
  assign data_take = take_ff;
  assign done = done_ff;
  assign nack = nack_ff;
  assign rd_byte = rd_ff;
endmodule

// File: rtl/eeprom_cache_pkg.sv
package eeprom_cache_pkg;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYC = SYS_CLK_HZ / (4 * SCL_HZ);
  localparam int PAGE_PROG_MS = 5;
  localparam int PAGE_PROG_CYC = PAGE_PROG_MS * (SYS_CLK_HZ / 1000);
  localparam int TMR_W = 24;
  localparam int QCNT_W = 8;
  // Device-type field of the control byte; value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 10;
  localparam int PTR_W = 6;
  localparam int PAGE_BYTES = 8;
  localparam int CACHE_PAGES = 8;
  localparam int CACHE_BYTES = 64;
  localparam int CTRL_RW_BIT = 0;
  localparam int CTRL_CS_LSB = 1;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int ADDR_HI_LSB = 8;
  localparam int BLK_LSB = 6;
  localparam int BLK_W = 4;
  localparam int ACK_BIT = 8;
  localparam int FIRST_DATA_IDX = 3;
  localparam logic SCL_IDLE = 1'b1;
  typedef enum logic [2:0] {
    P_IDLE, P_CTRL, P_ADDR_HI, P_ADDR_LO, P_DATA, P_READ
  } dev_phase_t;
  typedef enum logic [1:0] {PG_IDLE, PG_SCAN, PG_WAIT} prog_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
  typedef enum logic [1:0] {K_WRITE, K_POLL, K_READ} req_kind_t;
endpackage

// File: rtl/eeprom_link_if.sv
`timescale 1ns/100ps
interface eeprom_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe,
    input sda);
endinterface

// File: rtl/eeprom_write_cache_ctrl.sv
`timescale 1ns/100ps
module eeprom_write_cache_ctrl
  import eeprom_cache_pkg::*;
#(
  parameter int PROG_CYC = PAGE_PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Two-wire link
  eeprom_link_if.dev link,
  // Straps and supply
  input wire logic [2:0] chip_address_pins,
  input wire logic low_vdd,
  // Protection window, static from same-clock logic
  input wire logic [BLK_W-1:0] prot_start,
  input wire logic [BLK_W-1:0] prot_count,
  // Array read port
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Array page program port
  output logic pg_wr,
  output logic [PAGE_W-1:0] pg_addr,
  output logic [8*PAGE_BYTES-1:0] pg_data,
  output logic [PAGE_BYTES-1:0] pg_mask,
  // Status
  output logic busy,
  output logic standby,
  output logic vmon_en
);
  logic [5:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [2:0] cs_s;
  logic low_vdd_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  dev_phase_t phase_ff;
  logic [3:0] cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic ack_ff;
  logic oe_ff;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] start_ff;
  logic [ADDR_W-1:0] cur_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [7:0] cache_ff [CACHE_BYTES];
  logic [CACHE_BYTES-1:0] valid_ff;
  logic launch;
  prog_state_t pst_ff;
  logic [3:0] pidx_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [PAGE_W-1:0] page_now;
  logic [PAGE_BYTES-1:0] page_valid;
  logic [BLK_W-1:0] blk_now;
  logic [BLK_W:0] prot_end;
  logic prot_hit;
  logic pg_wr_ff;
  logic [PAGE_W-1:0] pg_addr_ff;
  logic [8*PAGE_BYTES-1:0] pg_data_ff;
  logic [PAGE_BYTES-1:0] pg_mask_ff;
  logic standby_ff;
  logic vmon_ff;
  logic bitv;

  bus_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({link.scl, link.sda, chip_address_pins, low_vdd}),
    .q(sync_q)
  );
  assign {scl_s, sda_s, cs_s, low_vdd_s} = sync_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  // Data edges with clock high mark frame boundaries
  assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign byte_in = {rx_ff[6:0], sda_s};
  assign launch = stop_det && phase_ff == P_DATA && |valid_ff;
  assign bitv = (cnt_ff == 4'h0) ? rd_data[7] : tx_ff[3'h7 - cnt_ff[2:0]];

  // Bit and byte sequencing on the link
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_ff <= P_IDLE;
      cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else if (start_det) begin
      phase_ff <= P_CTRL;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (stop_det) begin
      phase_ff <= P_IDLE;
      ack_ff <= 1'b0;
    end else if (scl_rise && phase_ff != P_IDLE) begin
      rx_ff <= byte_in;
      cnt_ff <= (cnt_ff == 4'(ACK_BIT)) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff == 4'(ACK_BIT)) begin
        ack_ff <= 1'b0;
        // Master nack ends a read; standby follows at once, without waiting for the stop
        if (phase_ff == P_READ && sda_s)
          phase_ff <= P_IDLE;
      end else if (cnt_ff == 4'h7) begin
        ack_ff <= phase_ff != P_READ;
        unique case (phase_ff)
          P_CTRL: begin
            if (byte_in[CTRL_TYPE_LSB +: 4] != DEV_TYPE ||
                byte_in[CTRL_CS_LSB +: 3] != cs_s || busy_ff_q()) begin
              ack_ff <= 1'b0;
              phase_ff <= P_IDLE;
            end else if (byte_in[CTRL_RW_BIT]) begin
              phase_ff <= P_READ;
            end else begin
              phase_ff <= P_ADDR_HI;
            end
          end
          P_ADDR_HI: phase_ff <= P_ADDR_LO;
          P_ADDR_LO: phase_ff <= P_DATA;
          P_DATA: phase_ff <= P_DATA;
          P_READ: phase_ff <= P_READ;
          P_IDLE: phase_ff <= P_IDLE;
        endcase
      end
    end
  end

  function automatic logic busy_ff_q();
    return pst_ff != PG_IDLE;
  endfunction

  // Open-drain drive: only low or released
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (start_det || stop_det) begin
      oe_ff <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_ff == 4'(ACK_BIT))
        oe_ff <= ack_ff;
      else if (phase_ff == P_READ)
        oe_ff <= !bitv;
      else
        oe_ff <= 1'b0;
      if (cnt_ff == 4'h0)
        tx_ff <= rd_data;
    end
  end

  // Address capture, cache load and access pointer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_ff <= '0;
      cur_ff <= '0;
      ptr_ff <= '0;
      valid_ff <= '0;
    end else if (scl_rise && cnt_ff == 4'h7 && !start_det && !stop_det) begin
      unique case (phase_ff)
        P_ADDR_HI: start_ff[ADDR_W-1:ADDR_HI_LSB] <= byte_in[4:0];
        P_ADDR_LO: begin
          start_ff[ADDR_HI_LSB-1:0] <= byte_in;
          cur_ff <= {start_ff[ADDR_W-1:ADDR_HI_LSB], byte_in};
          ptr_ff <= {3'h0, byte_in[2:0]};
          valid_ff <= '0;
        end
        P_DATA: begin
          cache_ff[ptr_ff] <= byte_in;
          valid_ff[ptr_ff] <= 1'b1;
          // Six-bit pointer wraps to page 0 and overwrites
          ptr_ff <= ptr_ff + 6'h01;
          cur_ff <= cur_ff + 13'h0001;
        end
        // Step only after a data byte went out, not after the control ack
        P_READ: cur_ff <= cur_ff + 13'h0001;
        default: begin
        end
      endcase
    end
  end

  assign page_now = start_ff[ADDR_W-1:3] + PAGE_W'(pidx_ff);
  assign page_valid = valid_ff[{pidx_ff[2:0], 3'h0} +: PAGE_BYTES];
  assign blk_now = page_now[BLK_LSB +: BLK_W];
  assign prot_end = {1'b0, prot_start} + {1'b0, prot_count};
  assign prot_hit = prot_count != '0 && blk_now >= prot_start &&
    {1'b0, blk_now} < prot_end;

  // Page-by-page timed programming
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pst_ff <= PG_IDLE;
      pidx_ff <= 4'h0;
      tmr_ff <= '0;
      pg_wr_ff <= 1'b0;
      pg_addr_ff <= '0;
      pg_data_ff <= '0;
      pg_mask_ff <= '0;
    end else begin
      pg_wr_ff <= 1'b0;
      unique case (pst_ff)
        PG_IDLE: begin
          if (launch) begin
            pst_ff <= PG_SCAN;
            pidx_ff <= 4'h0;
          end
        end
        PG_SCAN: begin
          if (pidx_ff == 4'(CACHE_PAGES)) begin
            pst_ff <= PG_IDLE;
          end else if (|page_valid) begin
            // Low supply blocks the write but keeps the timing
            pg_wr_ff <= !(vmon_ff && low_vdd_s);
            pg_addr_ff <= page_now;
            pg_mask_ff <= prot_hit ? '0 : page_valid;
            for (int i = 0; i < PAGE_BYTES; i++)
              pg_data_ff[8*i +: 8] <= cache_ff[{pidx_ff[2:0], 3'(i)}];
            // The scan cycle counts toward the page time
            tmr_ff <= TMR_W'(PROG_CYC - 2);
            pst_ff <= PG_WAIT;
          end else begin
            pidx_ff <= pidx_ff + 4'h1;
          end
        end
        PG_WAIT: begin
          if (tmr_ff == '0) begin
            pidx_ff <= pidx_ff + 4'h1;
            pst_ff <= PG_SCAN;
          end else begin
            tmr_ff <= tmr_ff - TMR_W'(1);
          end
        end
        default: pst_ff <= PG_IDLE;
      endcase
    end
  end

  // Standby once the link is quiet and programming is over
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      standby_ff <= 1'b1;
      vmon_ff <= 1'b0;
    end else begin
      standby_ff <= phase_ff == P_IDLE && pst_ff == PG_IDLE && !launch;
      vmon_ff <= !(phase_ff == P_IDLE && pst_ff == PG_IDLE && !launch);
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_ff;
  assign rd_addr = cur_ff;
  assign pg_wr = pg_wr_ff;
  assign pg_addr = pg_addr_ff;
  assign pg_data = pg_data_ff;
  assign pg_mask = pg_mask_ff;
  assign busy = pst_ff != PG_IDLE;
  assign standby = standby_ff;
  assign vmon_en = vmon_ff;
endmodule

// File: tb/eeprom_link_asserts.sv
`timescale 1ns/100ps
module eeprom_link_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link signals
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence seq_start;
    scl && $fell(sda);
  endsequence
  sequence seq_stop;
    scl && $rose(sda);
  endsequence
  chk_dev_open_drain: assert property (dev_sda_o == 1'b0)
    else $error("device drives data line high");
  chk_wired_level: assert property (sda == !(dev_sda_oe || host_sda_oe))
    else $error("data line level differs from pull-downs");
  chk_no_contention: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends pull the data line");
  chk_start_hold: assert property (seq_start |-> scl [*6])
    else $error("clock dropped too soon after start");
  chk_stop_idle: assert property (seq_stop |-> sda [*6])
    else $error("data line pulled too soon after stop");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*6])
    else $error("clock high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl [*6])
    else $error("clock low phase too short");
  // Device turns its driver only in the clock low phase
  chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data line with clock high");
  chk_dev_release: assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("device holds data line too long");
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import eeprom_cache_pkg::*;
  // Short page time keeps the run small; poll still sees busy
  localparam int PROG = 600;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] chip_address_pins = 3'h5;
  logic low_vdd = 1'b0;
  logic [BLK_W-1:0] prot_start = 4'h2;
  logic [BLK_W-1:0] prot_count = 4'h0;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic pg_wr, dev_busy, standby, vmon_en;
  logic [PAGE_W-1:0] pg_addr;
  logic [63:0] pg_data;
  logic [7:0] pg_mask;
  logic req_valid = 1'b0;
  req_kind_t req_kind = K_WRITE;
  logic [2:0] req_cs = 3'h0;
  logic [ADDR_W-1:0] req_addr = 13'h0000;
  logic [6:0] req_len = 7'h01;
  logic [7:0] wr_data = 8'h00;
  logic host_busy, data_take, done, nack;
  logic [7:0] rd_byte;
  logic [7:0] wbuf [128];
  logic [7:0] seed = 8'h2c;
  logic [PAGE_W-1:0] cap_a [$];
  logic [63:0] cap_d [$];
  logic [7:0] cap_m [$];
  int cap_c [$];
  int cyc = 0;
  int n_fail = 0;
  int n_checks = 0;
  always #25 clk_sys = ~clk_sys;
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  eeprom_link_if eeprom_link_if_i ();
  eeprom_write_cache_ctrl #(.PROG_CYC(PROG)) eeprom_write_cache_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .link(eeprom_link_if_i.dev),
    .chip_address_pins(chip_address_pins), .low_vdd(low_vdd),
    .prot_start(prot_start), .prot_count(prot_count), .rd_addr(rd_addr),
    .rd_data(rd_data), .pg_wr(pg_wr), .pg_addr(pg_addr), .pg_data(pg_data),
    .pg_mask(pg_mask), .busy(dev_busy), .standby(standby),
    .vmon_en(vmon_en));
  eeprom_bus_master #(.QTR(8)) eeprom_bus_master_i (
    .clk_sys(clk_sys), .rst(rst), .link(eeprom_link_if_i.host),
    .req_valid(req_valid), .req_kind(req_kind), .req_cs(req_cs),
    .req_addr(req_addr), .req_len(req_len), .wr_data(wr_data),
    .busy(host_busy), .data_take(data_take), .done(done), .nack(nack),
    .rd_byte(rd_byte));
  eeprom_link_asserts eeprom_link_asserts_i (
    .clk_sys(clk_sys), .rst(rst), .scl(eeprom_link_if_i.scl),
    .host_sda_o(eeprom_link_if_i.host_sda_o),
    .host_sda_oe(eeprom_link_if_i.host_sda_oe),
    .dev_sda_o(eeprom_link_if_i.dev_sda_o),
    .dev_sda_oe(eeprom_link_if_i.dev_sda_oe), .sda(eeprom_link_if_i.sda));
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (pg_wr === 1'b1) begin
      cap_a.push_back(pg_addr);
      cap_d.push_back(pg_data);
      cap_m.push_back(pg_mask);
      cap_c.push_back(cyc);
    end
  end
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  function automatic logic prot_hit(input logic [PAGE_W-1:0] pg);
    logic [4:0] b;
    b = {1'b0, pg[9:6]};
    return prot_count != 4'h0 && b >= 5'(prot_start) &&
      b < 5'(prot_start) + 5'(prot_count);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic too_long();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string s);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp,
    input string s);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic do_req(input req_kind_t k, input logic [2:0] cs,
    input logic [12:0] a, input int n);
    int i;
    int t;
    i = 0;
    t = 0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_kind = k;
    req_cs = cs;
    req_addr = a;
    req_len = 7'(n);
    wr_data = wbuf[0];
    while (host_busy !== 1'b1 && t < 10) begin
      @(negedge clk_sys);
      t++;
    end
    req_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 60000) begin
      @(negedge clk_sys);
      if (data_take === 1'b1) begin
        i++;
        wr_data = wbuf[i % 128];
      end
      t++;
    end
    if (t >= 60000) too_long();
  endtask
  task automatic check_pages(input logic [12:0] a, input int n,
    input logic off);
    logic [7:0] cb [64];
    logic [63:0] vm, bm, d;
    logic [7:0] m;
    logic [5:0] p;
    logic [PAGE_W-1:0] pg;
    int k;
    vm = 64'h0;
    p = {3'h0, a[2:0]};
    k = 0;
    for (int i = 0; i < n; i++) begin
      cb[p] = wbuf[i];
      vm[p] = 1'b1;
      p = p + 6'h01;
    end
    for (int g = 0; g < 8; g++) begin
      if (vm[8*g+:8] != 8'h00 && !off) begin
        pg = a[12:3] + PAGE_W'(g);
        m = prot_hit(pg) ? 8'h00 : vm[8*g+:8];
        for (int j = 0; j < 8; j++) begin
          bm[8*j+:8] = {8{m[j]}};
          d[8*j+:8] = cb[8*g+j];
        end
        if (k < cap_a.size()) begin
          chk_word(64'(cap_a[k]), 64'(pg), "page address");
          chk_word(64'(cap_m[k]), 64'(m), "page mask");
          chk_word(cap_d[k] & bm, d & bm, "page data");
          if (k > 0) chk_word(64'(cap_c[k] - cap_c[k-1]), 64'(PROG), "gap");
        end
        k++;
      end
    end
    chk_word(64'(cap_a.size()), 64'(k), "page count");
  endtask
  task automatic write_test(input logic [12:0] a, input int n,
    input logic [2:0] cs);
    logic ok;
    int t;
    ok = (cs === chip_address_pins);
    for (int i = 0; i < 128; i++) wbuf[i] = rnd();
    cap_a.delete();
    cap_d.delete();
    cap_m.delete();
    cap_c.delete();
    do_req(K_WRITE, cs, a, n);
    chk_flag(nack, !ok, "write ack");
    chk_flag(vmon_en, ok, "monitor while programming");
    if (ok) begin
      do_req(K_POLL, cs, a, 1);
      chk_flag(nack, 1'b0, "poll ack");
      chk_flag(dev_busy, 1'b0, "busy at poll ack");
    end
    t = 0;
    while ((dev_busy !== 1'b0 || standby !== 1'b1) && t < 20000) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 20000) too_long();
    chk_flag(vmon_en, 1'b0, "monitor on in standby");
    check_pages(a, n, !ok || low_vdd);
    $display("test done addr %h len %0d", a, n);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    write_test(13'h0018, 3, 3'h5);
    do_req(K_READ, 3'h5, 13'h0000, 1);
    chk_flag(nack, 1'b0, "read ack");
    chk_word(64'(rd_byte), 64'(8'h1b ^ 8'h5a), "read pointer");
    write_test(13'h01f8, 16, 3'h5);
    write_test(13'h001a, 66, 3'h5);
    prot_count = 4'h1;
    write_test(13'h03fc, 8, 3'h5);
    prot_count = 4'h0;
    low_vdd = 1'b1;
    write_test(13'h0100, 2, 3'h5);
    low_vdd = 1'b0;
    write_test(13'h0040, 2, 3'h2);
    for (int r = 0; r < 3; r++) begin
      write_test(13'({rnd(), rnd()}), int'(rnd() % 8'h14) + 1, 3'h5);
    end
    stop_test();
  end
endmodule
